// >>> logic/dscp_device.sv
// dscp_device: serial configuration port and register bank of the converter
// assumes: link pins arrive asynchronously; clk at least 4x the serial clock
// Functional notes
// - transactions framed only while chip select low
// - host keeps chip select low whole transaction
// - chip select high abandons, partial byte discarded
// - chip select high releases both data outputs
// - serial clock at most 40 MHz
// - input bits sampled on serial clock rise
// - read bits launched on serial clock fall
// - instruction and write data on data pin
// - port control bit 7 selects wiring mode
// - three-wire mode keeps separate output released
// - port control bit 6 selects bit order
// - change bit order in single-byte writes
// - soft reset held by bit 5, defaults reload
// - reads return last written defined bits
// - data control bit 7 selects input coding
// - data control bit 4 inverts clock output
// - power-down bits shut their circuits down
// - instruction: read flag, length, address
// - address decrements msb-first, increments lsb-first
// - register updates at each byte's last bit
// - chip select cycle restarts port, instruction next
module dscp_device #(
  parameter logic [7:0] CHIP_ID = 8'hA5 // arbitrary identification value
) (
  input wire logic clk, // 40 MHz system clock
  input wire logic resetn, // async reset, active low
  dscp_link_if.device link, // serial link pins
  input wire logic [2:0] input_margin_status, // margin and limit flags
  input wire logic [15:0] self_test_result1, // first self-test result
  input wire logic [15:0] self_test_result2, // second self-test result
  output logic three_wire_mode, // data pin bidirectional
  output logic bit_order_select, // lsb first when high
  output logic soft_reset_active, // controllers held in reset
  output logic data_unsigned, // unsigned input coding
  output logic clock_out_invert, // data clock output inverted
  output logic [7:0] power_down_control, // power-down bits
  output logic [7:0] input_window_timing, // setup and hold words
  output logic [4:0] sample_delay_adjust, // sampling delay word
  output logic [3:0] output_mode_select, // two 2-bit output modes
  output logic [9:0] conv1_fullscale, // first full-scale word
  output logic [9:0] conv2_fullscale, // second full-scale word
  output logic [11:0] aux1_control, // sign, direction, current
  output logic [11:0] aux2_control, // sign, direction, current
  output logic [2:0] self_test_control // enable, readback, clear
);
  import dscp_pkg::*;

  // ****************************************
  // pin synchronisation and edges
  // ****************************************
  logic [2:0] pins_s;
  logic sclk_q;
  logic cs_active;
  logic sclk_rise;
  logic sclk_fall;
  logic bit_in;

  dscp_sync3 #(.WIDTH(3), .INIT(3'b101)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .din({link.chip_select_n, link.sclk, link.sdio}),
    .dout(pins_s)
  );

  // edge detection on the filtered serial clock
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) sclk_q <= 1'b0;
    else sclk_q <= pins_s[1];
  end

  assign cs_active = ~pins_s[2];
  assign sclk_rise = pins_s[1] & ~sclk_q;
  assign sclk_fall = ~pins_s[1] & sclk_q;
  assign bit_in = pins_s[0];

  // ****************************************
  // register bank
  // ****************************************
  logic [7:0] regs [0:31];
  logic lsb_first;
  logic three_wire;
  logic soft_rst;
  logic wr_stb;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;

  assign lsb_first = regs[ADDR_PORT_CTRL][PC_ORDER_BIT];
  assign three_wire = regs[ADDR_PORT_CTRL][PC_WIRING_BIT];
  assign soft_rst = regs[ADDR_PORT_CTRL][PC_SOFT_RESET_BIT];

  // one flop byte per address; masked bits never store
  for (genvar g = 0; g < 32; g++) begin : g_reg
    localparam logic [4:0] A = 5'(g);
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        regs[g] <= dscp_rstval(A);
      end else if (soft_rst && A != ADDR_PORT_CTRL) begin
        regs[g] <= dscp_rstval(A);
      end else if (wr_stb && wr_addr == A) begin
        regs[g] <= (wr_data & dscp_wmask(A)) | (regs[g] & ~dscp_wmask(A));
      end
    end
  end

  // read value of one address
  function automatic logic [7:0] rd_val(input logic [4:0] a);
    if (a == ADDR_MARGIN) return {5'h00, input_margin_status};
    else if (a == ADDR_BIST1_LO) return self_test_result1[7:0];
    else if (a == ADDR_BIST1_HI) return self_test_result1[15:8];
    else if (a == ADDR_BIST2_LO) return self_test_result2[7:0];
    else if (a == ADDR_BIST2_HI) return self_test_result2[15:8];
    else if (a == ADDR_CHIP_ID) return CHIP_ID;
    else return regs[a];
  endfunction

  // ****************************************
  // serial port sequencer
  // ****************************************
  dscp_dev_state_t state;
  logic [2:0] cnt;
  logic [7:0] sr;
  logic [7:0] txsr;
  logic rw;
  logic [1:0] remaining;
  logic [4:0] addr;
  logic [7:0] next_sr;
  logic [4:0] next_addr;
  logic byte_done;
  logic rd_drive;
  logic out_bit;

  assign next_sr = lsb_first ? {bit_in, sr[7:1]} : {sr[6:0], bit_in};
  assign next_addr = lsb_first ? 5'(addr + 5'h01) : 5'(addr - 5'h01);
  assign byte_done = cs_active && sclk_rise && cnt == 3'h7 && state != DST_DONE;
  assign wr_stb = byte_done && state == DST_DATA && !rw;
  assign wr_addr = addr;
  assign wr_data = next_sr;
  assign rd_drive = state == DST_DATA && rw;
  assign out_bit = lsb_first ? txsr[0] : txsr[7];

  // bit counting, instruction decode and address stepping
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= DST_INSTR;
      cnt <= 3'h0;
      sr <= 8'h00;
      txsr <= 8'h00;
      rw <= 1'b0;
      remaining <= 2'h0;
      addr <= 5'h00;
    end else if (!cs_active) begin
      state <= DST_INSTR;
      cnt <= 3'h0;
      sr <= 8'h00;
    end else if (sclk_rise && state != DST_DONE) begin
      sr <= next_sr;
      cnt <= 3'(cnt + 3'h1);
      if (byte_done) begin
        case (state)
          DST_INSTR: begin
            rw <= next_sr[INSTR_READ_BIT];
            remaining <= next_sr[LENGTH_CODE_HIGH_BIT:LENGTH_CODE_LOW_BIT];
            addr <= next_sr[4:0];
            txsr <= rd_val(next_sr[4:0]);
            state <= DST_DATA;
          end
          DST_DATA: begin
            if (remaining == 2'h0) begin
              state <= DST_DONE;
            end else begin
              remaining <= 2'(remaining - 2'h1);
              addr <= next_addr;
              txsr <= rd_val(next_addr);
            end
          end
          default: state <= DST_DONE;
        endcase
      end
    end else if (sclk_fall && rd_drive) begin
      txsr <= lsb_first ? {1'b0, txsr[7:1]} : {txsr[6:0], 1'b0};
    end
  end

  // ****************************************
  // read-back drivers
  // ****************************************
  logic sdio_o;
  logic sdio_oe;
  logic sdo_o;
  logic sdo_oe;

  // launch on falling edge, release while deselected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sdio_o <= 1'b0;
      sdio_oe <= 1'b0;
      sdo_o <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (!cs_active) begin
      sdio_oe <= 1'b0;
      sdo_oe <= 1'b0;
    end else if (sclk_fall) begin
      sdio_o <= out_bit;
      sdo_o <= out_bit;
      sdio_oe <= rd_drive && three_wire;
      sdo_oe <= rd_drive && !three_wire;
    end
  end

  assign link.dev_sdio_o = sdio_o;
  assign link.dev_sdio_oe = sdio_oe;
  assign link.serial_out_pin_o = sdo_o;
  assign link.serial_out_pin_oe = sdo_oe;

  // ****************************************
  // configuration outputs, straight from the bank
  // ****************************************
  assign three_wire_mode = regs[ADDR_PORT_CTRL][PC_WIRING_BIT];
  assign bit_order_select = regs[ADDR_PORT_CTRL][PC_ORDER_BIT];
  assign soft_reset_active = regs[ADDR_PORT_CTRL][PC_SOFT_RESET_BIT];
  assign data_unsigned = regs[ADDR_DATA_FMT][DF_UNSIGNED_BIT];
  assign clock_out_invert = regs[ADDR_DATA_FMT][DF_CLK_INVERT_BIT];
  assign power_down_control = regs[ADDR_PWRDN];
  assign input_window_timing = regs[ADDR_WINDOW];
  assign sample_delay_adjust = regs[ADDR_DELAY][4:0];
  assign output_mode_select = regs[ADDR_OUT_MODE][3:0];
  assign conv1_fullscale = {regs[ADDR_FS1_HI][1:0], regs[ADDR_FS1_LO]};
  assign conv2_fullscale = {regs[ADDR_FS2_HI][1:0], regs[ADDR_FS2_LO]};
  assign aux1_control = {regs[ADDR_AUX1_HI][7:6], regs[ADDR_AUX1_HI][1:0], regs[ADDR_AUX1_LO]};
  assign aux2_control = {regs[ADDR_AUX2_HI][7:6], regs[ADDR_AUX2_HI][1:0], regs[ADDR_AUX2_LO]};
  assign self_test_control = regs[ADDR_BIST_CTRL][7:5];
endmodule

// >>> logic/dscp_pkg.sv
// dscp_pkg: shared constants for the serial configuration port
// assumes: included first; both ends import it, the link interface does not
package dscp_pkg;
  // ****************************************
  // device register addresses
  // ****************************************
  localparam logic [4:0] ADDR_PORT_CTRL = 5'h00;
  localparam logic [4:0] ADDR_DATA_FMT = 5'h02;
  localparam logic [4:0] ADDR_PWRDN = 5'h03;
  localparam logic [4:0] ADDR_WINDOW = 5'h04;
  localparam logic [4:0] ADDR_DELAY = 5'h05;
  localparam logic [4:0] ADDR_MARGIN = 5'h06;
  localparam logic [4:0] ADDR_OUT_MODE = 5'h0A;
  localparam logic [4:0] ADDR_FS1_LO = 5'h0B;
  localparam logic [4:0] ADDR_FS1_HI = 5'h0C;
  localparam logic [4:0] ADDR_AUX1_LO = 5'h0D;
  localparam logic [4:0] ADDR_AUX1_HI = 5'h0E;
  localparam logic [4:0] ADDR_FS2_LO = 5'h0F;
  localparam logic [4:0] ADDR_FS2_HI = 5'h10;
  localparam logic [4:0] ADDR_AUX2_LO = 5'h11;
  localparam logic [4:0] ADDR_AUX2_HI = 5'h12;
  localparam logic [4:0] ADDR_BIST_CTRL = 5'h1A;
  localparam logic [4:0] ADDR_BIST1_LO = 5'h1B;
  localparam logic [4:0] ADDR_BIST1_HI = 5'h1C;
  localparam logic [4:0] ADDR_BIST2_LO = 5'h1D;
  localparam logic [4:0] ADDR_BIST2_HI = 5'h1E;
  localparam logic [4:0] ADDR_CHIP_ID = 5'h1F;
  // ****************************************
  // field positions
  // ****************************************
  localparam int PC_WIRING_BIT = 7;
  localparam int PC_ORDER_BIT = 6;
  localparam int PC_SOFT_RESET_BIT = 5;
  localparam int DF_UNSIGNED_BIT = 7;
  localparam int DF_CLK_INVERT_BIT = 4;
  localparam int PWRDN_CLOCK_OUT_DRIVER_BIT = 7;
  localparam int PWRDN_DATA_INPUT_BIT = 6;
  localparam int PWRDN_AUX_CONV_B_BIT = 5;
  localparam int PWRDN_AUX_CONV_A_BIT = 4;
  localparam int PWRDN_REFERENCE_BIAS_BIT = 3;
  localparam int PWRDN_CONV_CLOCK_INPUT_BIT = 2;
  localparam int PWRDN_MAIN_CONV_B_BIT = 1;
  localparam int PWRDN_MAIN_CONV_A_BIT = 0;
  localparam int INSTR_READ_BIT = 7;
  localparam int LENGTH_CODE_HIGH_BIT = 6;
  localparam int LENGTH_CODE_LOW_BIT = 5;
  // ****************************************
  // writable masks and reset values
  // ****************************************
  localparam logic [7:0] MASK_PORT_CTRL = 8'hE0;
  localparam logic [7:0] MASK_DATA_FMT = 8'h90;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_DELAY = 8'h1F;
  localparam logic [7:0] MASK_OUT_MODE = 8'h0F;
  localparam logic [7:0] MASK_WORD_HI = 8'h03;
  localparam logic [7:0] MASK_AUX_HI = 8'hC3;
  localparam logic [7:0] MASK_BIST_CTRL = 8'hE0;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] RESET_ZERO = 8'h00;
  localparam logic [7:0] RESET_FS_LO = 8'hF9;
  localparam logic [7:0] RESET_FS_HI = 8'h01;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCLK_MIN_PERIOD_NS = 25;
  localparam int SCLK_MIN_HALF_CYC_RAW = (SCLK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) /
                                         (2 * CLK_PERIOD_NS);
  localparam int SCLK_MIN_HALF_CYC = (SCLK_MIN_HALF_CYC_RAW < 1) ? 1 : SCLK_MIN_HALF_CYC_RAW;
  localparam int SCLK_HALF_CYC = 8;
  // ****************************************
  // host register offsets
  // ****************************************
  localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
  localparam logic [7:0] HOST_WDATA_OFS = 8'h04;
  localparam logic [7:0] HOST_CMD_OFS = 8'h08;
  localparam logic [7:0] HOST_STATUS_OFS = 8'h0C;
  localparam logic [7:0] HOST_RDATA_OFS = 8'h10;
  // ****************************************
  // state encodings
  // ****************************************
  typedef enum logic [2:0] {
    DST_INSTR = 3'b001,
    DST_DATA = 3'b010,
    DST_DONE = 3'b100
  } dscp_dev_state_t;
  typedef enum logic [5:0] {
    HST_IDLE = 6'b000001,
    HST_SETUP = 6'b000010,
    HST_LOW = 6'b000100,
    HST_HIGH = 6'b001000,
    HST_END = 6'b010000,
    HST_GAP = 6'b100000
  } dscp_host_state_t;
  // writable bits of each address
  function automatic logic [7:0] dscp_wmask(input logic [4:0] a);
    if (a == ADDR_PORT_CTRL) return MASK_PORT_CTRL;
    else if (a == ADDR_DATA_FMT) return MASK_DATA_FMT;
    else if (a == ADDR_PWRDN || a == ADDR_WINDOW) return MASK_FULL;
    else if (a == ADDR_DELAY) return MASK_DELAY;
    else if (a == ADDR_OUT_MODE) return MASK_OUT_MODE;
    else if (a == ADDR_FS1_LO || a == ADDR_FS2_LO) return MASK_FULL;
    else if (a == ADDR_AUX1_LO || a == ADDR_AUX2_LO) return MASK_FULL;
    else if (a == ADDR_FS1_HI || a == ADDR_FS2_HI) return MASK_WORD_HI;
    else if (a == ADDR_AUX1_HI || a == ADDR_AUX2_HI) return MASK_AUX_HI;
    else if (a == ADDR_BIST_CTRL) return MASK_BIST_CTRL;
    else return MASK_NONE;
  endfunction
  // default value of each address
  function automatic logic [7:0] dscp_rstval(input logic [4:0] a);
    if (a == ADDR_FS1_LO || a == ADDR_FS2_LO) return RESET_FS_LO;
    else if (a == ADDR_FS1_HI || a == ADDR_FS2_HI) return RESET_FS_HI;
    else return RESET_ZERO;
  endfunction
endpackage

// >>> logic/dscp_link_if.sv
// dscp_link_if: serial link between controller and device
// assumes: pins idle high when nobody drives them
interface dscp_link_if;
  logic chip_select_n;
  logic sclk;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic serial_out_pin_o;
  logic serial_out_pin_oe;
  logic sdio;
  logic serial_out_pin;
  // wire levels from the enables, pull-up when released
  assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);
  assign serial_out_pin = serial_out_pin_oe ? serial_out_pin_o : 1'b1;
  modport host (output chip_select_n, sclk, host_sdio_o, host_sdio_oe,
                input sdio, serial_out_pin);
  modport device (input chip_select_n, sclk, sdio,
                  output dev_sdio_o, dev_sdio_oe, serial_out_pin_o, serial_out_pin_oe);
endinterface

// >>> logic/dscp_sync3.sv
// dscp_sync3: three-stage input synchroniser with agreement filter
// assumes: inputs asynchronous to clk
module dscp_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk, // sampling clock
  input wire logic resetn, // async reset, active low
  input wire logic [WIDTH-1:0] din, // raw pins
  output logic [WIDTH-1:0] dout // filtered level
);
  logic [WIDTH-1:0] s1, s2, s3;
  // ****************************************
  // stages; output follows once stages two and three agree
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      dout <= INIT;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2[i] == s3[i]) dout[i] <= s3[i];
      end
    end
  end
endmodule

// >>> logic/dscp_host.sv
// dscp_host: serial link controller, ordered over an AHB-Lite slave port
// assumes: software mirrors the device's wiring and bit-order settings here
module dscp_host #(
  parameter int SCLK_HALF = dscp_pkg::SCLK_HALF_CYC // clk cycles per serial half period
) (
  input wire logic clk, // 40 MHz system clock
  input wire logic resetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  dscp_link_if.host link // serial link pins
);
  import dscp_pkg::*;

  // ****************************************
  // bus slave, one wait state per transfer
  // ****************************************
  logic pend;
  logic pw;
  logic [7:0] pa;
  logic sel_ok;
  logic wr;
  logic start;
  logic lsb_first;
  logic three_wire;
  logic done;
  logic [31:0] wdata;
  logic [3:0][7:0] rdata;
  logic [31:0] rd_mux;
  dscp_host_state_t state;

  assign sel_ok = hsel && htrans[1] && hready;
  assign wr = pend && pw;
  assign start = wr && pa == HOST_CMD_OFS && state == HST_IDLE;
  assign rd_mux = (pa == HOST_CTRL_OFS) ? {30'h0, three_wire, lsb_first} :
                  (pa == HOST_WDATA_OFS) ? wdata :
                  (pa == HOST_STATUS_OFS) ? {30'h0, done, state != HST_IDLE} :
                  (pa == HOST_RDATA_OFS) ? rdata : 32'h0;

  // address phase capture and data phase answer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend <= 1'b0;
      pw <= 1'b0;
      pa <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
      hresp <= 1'b0;
    end else begin
      pend <= sel_ok;
      if (sel_ok) begin
        pa <= haddr[7:0];
        pw <= hwrite;
        hreadyout <= 1'b0;
      end else if (pend) begin
        hreadyout <= 1'b1;
        hrdata <= pw ? 32'h0 : rd_mux;
      end
    end
  end

  // control, write data and sticky done (set wins over clear)
  logic finish;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lsb_first <= 1'b0;
      three_wire <= 1'b0;
      wdata <= 32'h0;
      done <= 1'b0;
    end else begin
      if (wr && pa == HOST_CTRL_OFS) {three_wire, lsb_first} <= hwdata[1:0];
      if (wr && pa == HOST_WDATA_OFS) wdata <= hwdata;
      if (finish) done <= 1'b1;
      else if (wr && pa == HOST_STATUS_OFS && hwdata[1]) done <= 1'b0;
    end
  end

  // ****************************************
  // serial engine
  // ****************************************
  logic [1:0] pins_s;
  logic [7:0] div;
  logic div_end;
  logic [7:0] instr;
  logic [2:0] byte_idx;
  logic [2:0] bit_idx;
  logic [2:0] nbyte;
  logic [2:0] nbit;
  logic [7:0] rx;
  logic [7:0] next_rx;
  logic rd_bit;
  logic last_bit;
  logic cs_n;
  logic sclk;
  logic sdio_o;
  logic sdio_oe;

  dscp_sync3 #(.WIDTH(2), .INIT(2'b11)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .din({link.sdio, link.serial_out_pin}),
    .dout(pins_s)
  );

  // bit to send at a given byte and bit position
  function automatic logic tx_bit(input logic [2:0] b, input logic [2:0] i);
    logic [7:0] v;
    v = (b == 3'h0) ? instr : wdata[8 * (b - 3'h1) +: 8];
    return lsb_first ? v[i] : v[3'h7 - i];
  endfunction

  assign div_end = div == 8'(SCLK_HALF - 1);
  assign nbit = 3'(bit_idx + 3'h1);
  assign nbyte = (bit_idx == 3'h7) ? 3'(byte_idx + 3'h1) : byte_idx;
  assign rd_bit = three_wire ? pins_s[1] : pins_s[0];
  assign next_rx = lsb_first ? {rd_bit, rx[7:1]} : {rx[6:0], rd_bit};
  assign last_bit = bit_idx == 3'h7 && byte_idx == 3'({1'b0, instr[6:5]} + 3'h1);
  assign finish = state == HST_GAP && div_end;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= HST_IDLE;
      div <= 8'h00;
      instr <= 8'h00;
      byte_idx <= 3'h0;
      bit_idx <= 3'h0;
      rx <= 8'h00;
      rdata <= '0;
      cs_n <= 1'b1;
      sclk <= 1'b0;
      sdio_o <= 1'b0;
      sdio_oe <= 1'b0;
    end else begin
      div <= (state == HST_IDLE || div_end) ? 8'h00 : 8'(div + 8'h01);
      case (state)
        HST_IDLE: if (start) begin
          instr <= hwdata[7:0];
          byte_idx <= 3'h0;
          bit_idx <= 3'h0;
          cs_n <= 1'b0;
          state <= HST_SETUP;
        end
        HST_SETUP: if (div_end) begin
          sdio_o <= tx_bit(3'h0, 3'h0);
          sdio_oe <= 1'b1;
          state <= HST_LOW;
        end
        HST_LOW: if (div_end) begin
          sclk <= 1'b1;
          state <= HST_HIGH;
        end
        HST_HIGH: if (div_end) begin
          if (instr[7] && byte_idx != 3'h0) begin
            rx <= next_rx;
            if (bit_idx == 3'h7) rdata[byte_idx - 3'h1] <= next_rx;
          end
          sclk <= 1'b0;
          bit_idx <= nbit;
          byte_idx <= nbyte;
          sdio_o <= tx_bit(nbyte, nbit);
          sdio_oe <= !last_bit && !(instr[7] && nbyte != 3'h0); // released after last bit
          state <= last_bit ? HST_END : HST_LOW;
        end
        HST_END: if (div_end) begin
          cs_n <= 1'b1;
          sdio_oe <= 1'b0;
          state <= HST_GAP;
        end
        HST_GAP: if (div_end) state <= HST_IDLE;
        default: state <= HST_IDLE;
      endcase
    end
  end

  assign link.chip_select_n = cs_n;
  assign link.sclk = sclk;
  assign link.host_sdio_o = sdio_o;
  assign link.host_sdio_oe = sdio_oe;
endmodule

// >>> verification/dscp_link_props.sv
// dscp_link_props: link-level checks between controller and device
// assumes: bench clock and reset, signals taken from dscp_link_if
module dscp_link_props (
  input wire logic clk, // sampling clock
  input wire logic resetn, // async reset, active low
  input wire logic chip_select_n, // frame select
  input wire logic sclk, // serial clock
  input wire logic host_sdio_oe, // controller drives data pin
  input wire logic dev_sdio_o, // device data pin value
  input wire logic dev_sdio_oe, // device drives data pin
  input wire logic serial_out_pin_o, // separate output value
  input wire logic serial_out_pin_oe // separate output enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // frame end and released outputs
  sequence s_frame_end;
    $rose(chip_select_n);
  endsequence
  sequence s_released;
    !dev_sdio_oe && !serial_out_pin_oe;
  endsequence
  a_release_on_end: assert property (s_frame_end |-> ##[0:8] s_released)
    else $error("outputs not released after frame end");
  a_stay_released: assert property (chip_select_n [*8] |-> s_released)
    else $error("output driven while deselected");
  a_one_driver: assert property (dev_sdio_oe |-> !serial_out_pin_oe && !host_sdio_oe)
    else $error("two drivers on the read path");
  a_drive_in_frame: assert property (
    $rose(dev_sdio_oe || serial_out_pin_oe) |-> !chip_select_n)
    else $error("output enabled outside a frame");
  a_launch_on_fall: assert property (serial_out_pin_oe && $past(serial_out_pin_oe) &&
    $changed(serial_out_pin_o) |-> !sclk && !$past(sclk))
    else $error("read bit changed outside low phase");
  a_hold_while_high: assert property (
    dev_sdio_oe && $past(dev_sdio_oe) && sclk |-> $stable(dev_sdio_o))
    else $error("read bit moved while clock high");
  a_sclk_idle: assert property (chip_select_n |-> !sclk)
    else $error("serial clock not idle low");
  a_cs_gap: assert property (s_frame_end |=> chip_select_n [*7])
    else $error("deselect gap too short");
endmodule

// >>> verification/dac_serial_config_port_tb_top.sv
// dac_serial_config_port_tb_top: controller and device joined over the link
// assumes: software mirrors wiring and bit order into the controller
module dac_serial_config_port_tb_top import dscp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, tw, bo, sr, du, ci;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
  logic hreadyout;
  logic [7:0] pd, iw;
  logic [4:0] sd;
  logic [9:0] f1, f2;
  logic [11:0] a1;
  int errors = 0, samples_checked = 0;
  always #12.5 clk = ~clk;
  dscp_link_if link_i ();
  dscp_device u_dscp_device (.clk(clk), .resetn(resetn), .link(link_i.device),
    .input_margin_status(3'h5), .self_test_result1(16'h0), .self_test_result2(16'h0),
    .three_wire_mode(tw), .bit_order_select(bo), .soft_reset_active(sr), .data_unsigned(du),
    .clock_out_invert(ci), .power_down_control(pd), .input_window_timing(iw),
    .sample_delay_adjust(sd), .output_mode_select(), .conv1_fullscale(f1),
    .conv2_fullscale(f2), .aux1_control(a1), .aux2_control(), .self_test_control());
  dscp_host u_dscp_host (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .link(link_i.host));
  dscp_link_props u_props (.clk(clk), .resetn(resetn), .chip_select_n(link_i.chip_select_n),
    .sclk(link_i.sclk), .host_sdio_oe(link_i.host_sdio_oe), .dev_sdio_o(link_i.dev_sdio_o),
    .dev_sdio_oe(link_i.dev_sdio_oe), .serial_out_pin_o(link_i.serial_out_pin_o),
    .serial_out_pin_oe(link_i.serial_out_pin_oe));
  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one single-word bus transfer, entered just after a rising edge
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  // one serial frame: load data, issue instruction, wait done, fetch read data
  task xfer(input logic [7:0] ins, input logic [31:0] wd);
    int n;
    n = 0;
    ahb(1, HOST_WDATA_OFS, wd);
    ahb(1, HOST_CMD_OFS, {24'h0, ins});
    do begin
      ahb(0, HOST_STATUS_OFS, 0);
      n++;
    end while (rd[1] !== 1'b1 && n < 500);
    if (rd[1] !== 1'b1) begin
      errors++;
      give_verdict;
    end
    ahb(1, HOST_STATUS_OFS, 32'h2);
    ahb(0, HOST_RDATA_OFS, 0);
  endtask
  task give_verdict;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk(f1, 32'h1F9);
    xfer(8'h02, 32'h90);
    chk({du, ci}, 32'h3);
    xfer(8'h45, 32'h81A51F);
    chk({pd, iw, 3'h0, sd}, 32'h81A51F);
    xfer(8'hE6, 0);
    chk(rd, 32'h81A51F05);
    xfer(8'h87, 0);
    chk(rd[7:0], 0);
    ahb(0, 8'h20, 0);
    chk(rd, 0);
    xfer(8'h00, 32'h80);
    ahb(1, HOST_CTRL_OFS, 32'h2);
    chk(tw, 1);
    xfer(8'h83, 0);
    chk(rd[7:0], 32'h81);
    xfer(8'h00, 32'hC0);
    ahb(1, HOST_CTRL_OFS, 32'h3);
    chk(bo, 1);
    xfer(8'h2B, 32'h0234);
    chk(f1, 32'h234);
    xfer(8'h00, 32'hE0);
    chk(sr, 1);
    xfer(8'h00, 32'hC0);
    chk({bo, pd, 2'h0, f1}, 32'h1001F9);
    xfer(8'h6D, 32'h0356C312);
    chk({a1, 2'h0, f2}, 32'hF12356);
    give_verdict;
  end
  // hang guard
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    give_verdict;
  end
endmodule
